//--- hdl/pwt_regs.svh
// Register map, field positions, reset values and counts of the wakeup timer
`ifndef PWT_REGS_SVH
`define PWT_REGS_SVH
`define PWT_ADDR_DIV 8'h00
`define PWT_ADDR_CTRL 8'h01
`define PWT_ADDR_RST 8'h02
`define PWT_FLAG_BIT 7
`define PWT_ACK_BIT 6
`define PWT_FIELD_MSB 5
`define PWT_DIV_POR 6'h1F
`define PWT_DIV_FORCE 6'h3F
`define PWT_WUT_RESET 6'h3F
`define PWT_PRST_RESET 6'h3F
`define PWT_PRESC_BASE 11'h1F8
`define PWT_PRESC_STEP_SHIFT 4
`define PWT_READ_IDLE 8'h00
`endif

//--- hdl/pwt_pkg.sv
// Types shared by the wakeup timer modules
package pwt_pkg;
   typedef logic [5:0] pwt_field_t;
   typedef logic [10:0] pwt_presc_t;

   typedef struct packed {
      pwt_field_t prescaleValue;
      pwt_presc_t prescaleCount;
      logic wclkTick;
   } pwt_presc_state_t;

   typedef struct packed {
      logic lfoSync1;
      logic lfoSync2;
      logic lfoPrev;
      logic wakeupFlag;
      pwt_field_t wakeupInterval;
      pwt_field_t resetInterval;
      pwt_field_t wakeupCount;
      pwt_field_t resetCount;
      logic wakeupIrq;
      logic periodicReset;
      logic [7:0] rdData;
   } pwt_main_state_t;
endpackage

//--- hdl/pwt_div_if.sv
// Link between the timer core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface pwt_div_if;
   logic lfoTick;
   logic divWrite;
   pwt_pkg::pwt_field_t divData;
   pwt_pkg::pwt_field_t prescaleValue;
   logic wclkTick;

   modport core
   (
      output lfoTick, divWrite, divData,
      input prescaleValue, wclkTick
   );

   modport presc
   (
      input lfoTick, divWrite, divData,
      output prescaleValue, wclkTick
   );
endinterface
`default_nettype wire

//--- hdl/pwt_prescaler.sv
// Wakeup clock prescaler and its divider register
`timescale 1ns/1ps
`default_nettype none
`include "pwt_regs.svh"
module pwt_prescaler
(
   // Clock and power-on reset
   input wire logic core_clk,
   input wire logic porReset,
   // Core link
   pwt_div_if.presc bus
);
   localparam pwt_pkg::pwt_presc_state_t PRESC_RESET =
      '{`PWT_DIV_POR, 11'h000, 1'b0};

   pwt_pkg::pwt_presc_state_t s;
   pwt_pkg::pwt_presc_state_t n;
   pwt_pkg::pwt_presc_t periodLast;

   always_comb
   begin
      n = s;
      n.wclkTick = 1'b0;
      // Six divider bits scaled by sixteen on top of the base count
      periodLast = `PWT_PRESC_BASE +
         {1'b0, s.prescaleValue, 4'h0} - 11'h001;
      if (bus.lfoTick)
      begin
         // Greater-or-equal so a smaller divider never runs the count out
         if (s.prescaleCount >= periodLast)
         begin
            n.prescaleCount = 11'h000;
            n.wclkTick = 1'b1;
         end
         else
            n.prescaleCount = s.prescaleCount + 11'h001;
      end
      if (bus.divWrite)
         n.prescaleValue = bus.divData;
   end

   // Only power-on reset reaches the divider, other resets leave it
   always_ff @(posedge core_clk or posedge porReset)
   begin
      if (porReset)
         s <= PRESC_RESET;
      else
         s <= n;
   end

   assign bus.prescaleValue = s.prescaleValue;
   assign bus.wclkTick = s.wclkTick;

   // A smaller divider may leave the count above the period until a tick
   chk_presc_count_bound: assert property (
      @(posedge core_clk) disable iff (porReset)
      bus.lfoTick && s.prescaleCount >= periodLast
      |=> s.prescaleCount == 11'h000 && s.wclkTick)
      else $error("prescale count did not wrap at its period");

   chk_presc_tick_wrap: assert property (
      @(posedge core_clk) disable iff (porReset)
      s.wclkTick |-> s.prescaleCount == 11'h000)
      else $error("wakeup clock without prescaler wrap");
endmodule // pwt_prescaler
`default_nettype wire

//--- hdl/pwt_timer.sv
// Periodic wakeup timer with periodic reset and register port
`timescale 1ns/1ps
`default_nettype none
`include "pwt_regs.svh"
module pwt_timer
(
   // Clock and resets
   input wire logic core_clk,
   input wire logic reset,
   input wire logic powerOnReset,
   // Low frequency oscillator pin
   input wire logic lfoClk,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // Events
   output logic wakeupIrq,
   output logic periodicReset
);
   localparam pwt_pkg::pwt_main_state_t MAIN_RESET = '{
      1'b0, 1'b0, 1'b0, 1'b0,
      `PWT_WUT_RESET, `PWT_PRST_RESET,
      6'h00, 6'h00, 1'b0, 1'b0, `PWT_READ_IDLE};

   pwt_pkg::pwt_main_state_t s;
   pwt_pkg::pwt_main_state_t n;
   logic anyReset;
   logic wakeEnd;
   logic resetFire;
   logic irqFire;
   logic ctrlWrite;
   logic rstWrite;
   logic divWrite;
   logic ackWrite;
   pwt_pkg::pwt_field_t wrField;

   pwt_div_if divBus();

   // Power-on reset is also a reset of every other register
   assign anyReset = reset | powerOnReset;

   pwt_prescaler presc
   (
      .core_clk(core_clk),
      .porReset(powerOnReset),
      .bus(divBus)
   );

   assign ctrlWrite = regWrite && regAddr == `PWT_ADDR_CTRL;
   assign rstWrite = regWrite && regAddr == `PWT_ADDR_RST;
   assign divWrite = regWrite && regAddr == `PWT_ADDR_DIV;
   assign ackWrite = ctrlWrite && regWrData[`PWT_ACK_BIT];
   assign wrField = regWrData[`PWT_FIELD_MSB:0];

   // Zero interval still wraps after 64 clocks, so the reset side keeps
   // its clock while the wakeup interrupt is off
   assign wakeEnd = divBus.wclkTick &&
      s.wakeupCount == s.wakeupInterval - 6'h01;
   assign resetFire = wakeEnd && s.resetInterval != 6'h00 &&
      s.resetCount == s.resetInterval - 6'h01;
   assign irqFire = wakeEnd && s.wakeupInterval != 6'h00 &&
      !resetFire;

   assign divBus.lfoTick = s.lfoSync2 && !s.lfoPrev;

   always_comb
   begin
      n = s;
      n.lfoSync1 = lfoClk;
      n.lfoSync2 = s.lfoSync1;
      n.lfoPrev = s.lfoSync2;
      n.wakeupIrq = irqFire;
      n.periodicReset = resetFire;
      n.rdData = `PWT_READ_IDLE;
      divBus.divWrite = 1'b0;
      divBus.divData = wrField;

      // Wakeup counter runs on the wakeup clock
      if (divBus.wclkTick)
      begin
         if (wakeEnd)
            n.wakeupCount = 6'h00;
         else
            n.wakeupCount = s.wakeupCount + 6'h01;
      end

      // Each wakeup interval end is one tick of the reset counter
      if (wakeEnd)
      begin
         if (resetFire || s.resetInterval == 6'h00)
            n.resetCount = 6'h00;
         else
            n.resetCount = s.resetCount + 6'h01;
      end

      // Set wins over an acknowledge in the same cycle
      if (irqFire)
         n.wakeupFlag = 1'b1;
      else if (ackWrite)
         n.wakeupFlag = 1'b0;

      // Divider write keeps only the six low bits
      if (divWrite)
      begin
         divBus.divWrite = 1'b1;
         divBus.divData = wrField;
      end

      if (ctrlWrite)
      begin
         if (wrField == 6'h00)
         begin
            // Refused when it would leave neither wakeup nor reset
            if (s.resetInterval != 6'h00)
            begin
               n.wakeupInterval = 6'h00;
               // Zero already held is the same value, the count runs on
               if (s.wakeupInterval != 6'h00)
                  n.wakeupCount = 6'h00;
               divBus.divWrite = 1'b1;
               divBus.divData = `PWT_DIV_FORCE;
            end
         end
         else if (wrField != s.wakeupInterval)
         begin
            n.wakeupInterval = wrField;
            n.wakeupCount = 6'h00;
         end
      end

      if (rstWrite)
      begin
         // Clearing is inhibited while the wakeup interval is zero
         if (wrField == 6'h00 && s.wakeupInterval == 6'h00)
            n.resetInterval = s.resetInterval;
         else if (wrField != s.resetInterval)
         begin
            n.resetInterval = wrField;
            n.resetCount = 6'h00;
         end
      end

      if (regRead)
      begin
         case (regAddr)
            `PWT_ADDR_DIV:
               n.rdData = {2'b00, divBus.prescaleValue};
            `PWT_ADDR_CTRL:
               n.rdData = {s.wakeupFlag, 1'b0, s.wakeupInterval};
            `PWT_ADDR_RST:
               n.rdData = {2'b00, s.resetInterval};
            default:
               n.rdData = `PWT_READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge anyReset)
   begin
      if (anyReset)
         s <= MAIN_RESET;
      else
         s <= n;
   end

   assign regRdData = s.rdData;
   assign wakeupIrq = s.wakeupIrq;
   assign periodicReset = s.periodicReset;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (anyReset);

   sequence ctrlZeroWrite;
      ctrlWrite && wrField == 6'h00;
   endsequence

   sequence rstZeroWrite;
      rstWrite && wrField == 6'h00;
   endsequence

   sequence ctrlNewValue;
      ctrlWrite && wrField != 6'h00 && wrField != s.wakeupInterval;
   endsequence

   sequence ackNoEvent;
      ackWrite && !irqFire;
   endsequence

   chk_flag_on_irq: assert property (
      s.wakeupIrq |-> s.wakeupFlag)
      else $error("interrupt without its flag");

   chk_flag_zero_write: assert property (
      s.wakeupFlag && ctrlWrite && !regWrData[`PWT_ACK_BIT]
      |=> s.wakeupFlag)
      else $error("flag lost without acknowledge");

   chk_flag_ack_clears: assert property (
      ackNoEvent |=> !s.wakeupFlag)
      else $error("acknowledge did not clear flag");

   chk_ack_reads_zero: assert property (
      regRead && regAddr == `PWT_ADDR_CTRL |=> !regRdData[`PWT_ACK_BIT]
      ##1 regRdData == `PWT_READ_IDLE || $past(regRead))
      else $error("acknowledge bit read as one");

   chk_interval_restart: assert property (
      ctrlNewValue |=> s.wakeupCount == 6'h00
      && s.wakeupInterval == $past(wrField))
      else $error("new interval did not restart count");

   chk_same_value_kept: assert property (
      ctrlWrite && wrField == s.wakeupInterval && !divBus.wclkTick
      |=> $stable(s.wakeupCount))
      else $error("same interval disturbed the count");

   chk_zero_forces_div: assert property (
      ctrlZeroWrite and s.resetInterval != 6'h00
      |=> s.wakeupInterval == 6'h00
      && divBus.prescaleValue == `PWT_DIV_FORCE)
      else $error("zero interval did not force divider");

   chk_zero_refused: assert property (
      ctrlZeroWrite and s.resetInterval == 6'h00
      |=> $stable(s.wakeupInterval) && $stable(divBus.prescaleValue))
      else $error("refused zero interval took effect");

   chk_reset_clear_gate: assert property (
      rstZeroWrite and s.wakeupInterval == 6'h00
      |=> s.resetInterval == $past(s.resetInterval))
      else $error("reset interval cleared with wakeup off");

   chk_never_both_off: assert property (
      !(s.wakeupInterval == 6'h00 && s.resetInterval == 6'h00))
      else $error("wakeup and reset both disabled");

   chk_count_in_range: assert property (
      s.wakeupInterval != 6'h00 && !$past(ctrlWrite)
      |-> s.wakeupCount < s.wakeupInterval)
      else $error("wakeup count past its interval");

   chk_irq_clocks_reset: assert property (
      irqFire && s.resetInterval != 6'h00
      |=> s.resetCount == $past(s.resetCount) + 6'h01
      || $past(rstWrite))
      else $error("wakeup did not clock the reset counter");

   chk_reset_wins: assert property (
      s.periodicReset |-> !s.wakeupIrq)
      else $error("interrupt beside periodic reset");

   chk_div_upper_zero: assert property (
      regRead && regAddr == `PWT_ADDR_DIV |=> regRdData[7:6] == 2'b00)
      else $error("divider upper bits read nonzero");

   chk_read_one_cycle: assert property (
      !regRead |=> regRdData == `PWT_READ_IDLE)
      else $error("read data outside its cycle");

   sequence wakeEndSeen;
      wakeEnd;
   endsequence

   sequence rstNewValue;
      rstWrite && wrField != s.resetInterval
      && !(wrField == 6'h00 && s.wakeupInterval == 6'h00);
   endsequence

   chk_irq_one_cycle: assert property (
      s.wakeupIrq |=> !s.wakeupIrq)
      else $error("wakeup interrupt longer than one cycle");

   chk_irq_at_interval: assert property (
      wakeEndSeen and s.wakeupInterval != 6'h00 and !resetFire
      |=> s.wakeupIrq && s.wakeupFlag)
      else $error("interval end without interrupt");

   chk_no_irq_when_off: assert property (
      s.wakeupInterval == 6'h00 && !$past(ctrlWrite) |-> !s.wakeupIrq)
      else $error("interrupt while wakeup is disabled");

   chk_zero_count_kept: assert property (
      ctrlZeroWrite and s.wakeupInterval == 6'h00 and !divBus.wclkTick
      |=> $stable(s.wakeupCount))
      else $error("repeated zero interval disturbed the count");

   chk_wrap_to_zero: assert property (
      wakeEndSeen and !ctrlWrite |=> s.wakeupCount == 6'h00)
      else $error("wakeup count did not return to zero");

   chk_reset_restart: assert property (
      rstNewValue |=> s.resetCount == 6'h00
      && s.resetInterval == $past(wrField))
      else $error("new reset interval did not restart count");

   chk_reset_count_range: assert property (
      s.resetInterval != 6'h00 && !$past(rstWrite)
      |-> s.resetCount < s.resetInterval)
      else $error("reset count past its interval");

   chk_reset_pulse: assert property (
      s.periodicReset |=> !s.periodicReset)
      else $error("periodic reset longer than one cycle");

   chk_reset_off_held: assert property (
      s.resetInterval == 6'h00 |-> s.resetCount == 6'h00 && !resetFire)
      else $error("periodic reset counter runs while disabled");

   chk_div_write_taken: assert property (
      divWrite |=> divBus.prescaleValue == $past(wrField))
      else $error("divider write not taken");

   chk_rst_reads_back: assert property (
      regRead && regAddr == `PWT_ADDR_RST
      |=> regRdData == {2'b00, $past(s.resetInterval)})
      else $error("reset interval read back wrong");

   // A tick lasts one cycle, so the prescaler never counts one edge twice
   chk_lfo_tick_single: assert property (
      divBus.lfoTick |=> !divBus.lfoTick)
      else $error("oscillator tick longer than one cycle");
endmodule // pwt_timer
`default_nettype wire

//--- verification/test_pwt_timer.sv
// Self-checking testbench of the periodic wakeup timer
`timescale 1ns/1ps
`default_nettype none
`include "pwt_regs.svh"
module test_pwt_timer;
   // Oscillator tick every 4 core cycles keeps the run short
   localparam int WCLK_CYC = 504 * 4;
   localparam int LIMIT = 60000;
   logic core_clk;
   logic reset;
   logic powerOnReset;
   logic lfoClk;
   logic [1:0] lfoDiv;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic regWrite;
   logic regRead;
   logic [7:0] regRdData;
   logic wakeupIrq;
   logic periodicReset;
   int cyc;
   int n_errors;
   int n_compared;
   int t0;
   int t1;
   logic r0;

   pwt_timer DUT
   (
      .core_clk(core_clk),
      .reset(reset),
      .powerOnReset(powerOnReset),
      .lfoClk(lfoClk),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regWrite(regWrite),
      .regRead(regRead),
      .regRdData(regRdData),
      .wakeupIrq(wakeupIrq),
      .periodicReset(periodicReset)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Oscillator runs free, two cycles high and two low
   always @(posedge core_clk)
   begin
      lfoDiv <= lfoDiv + 2'h1;
      lfoClk <= lfoDiv[1];
   end

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         n_errors = n_errors + 1;
         final_report();
      end
   end

   task final_report;
      if (n_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(string n, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         n_errors++;
      end
   endtask

   task chk_n(string n, int e, int g);
      n_compared++;
      if (g != e)
      begin
         $display("wrong value %s expected %0d seen %0d", n, e, g);
         n_errors++;
      end
   endtask

   task wr(logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task rd(string n, logic [7:0] a, logic [7:0] e, logic [7:0] m);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(negedge core_clk);
      chk(n, e, regRdData & m);
   endtask

   // Bounded wait for the next event pulse
   task wait_ev(output int t, output logic isRst);
      int k;
      for (k = 0; k < 20000; k++)
      begin
         @(negedge core_clk);
         if (wakeupIrq === 1'b1 || periodicReset === 1'b1)
            break;
      end
      // A missing event counts against the run
      if (k == 20000)
      begin
         $display("wrong value event expected pulse seen none");
         n_errors++;
      end
      t = cyc;
      isRst = periodicReset;
   endtask

   task test_reset_values;
      rd("divider", `PWT_ADDR_DIV, 8'h1F, 8'hFF);
      rd("control", `PWT_ADDR_CTRL, 8'h3F, 8'hFF);
      rd("reset interval", `PWT_ADDR_RST, 8'h3F, 8'hFF);
      rd("unmapped", 8'h03, 8'h00, 8'hFF);
      wr(`PWT_ADDR_DIV, 8'hFF);
      rd("divider upper", `PWT_ADDR_DIV, 8'h3F, 8'hFF);
      wr(`PWT_ADDR_CTRL, 8'h05);
      rd("control taken", `PWT_ADDR_CTRL, 8'h05, 8'hFF);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rd("divider kept", `PWT_ADDR_DIV, 8'h3F, 8'hFF);
      rd("control reset", `PWT_ADDR_CTRL, 8'h3F, 8'hFF);
   endtask

   task test_interval_timing;
      int t2;
      int t3;
      wr(`PWT_ADDR_DIV, 8'h00);
      wr(`PWT_ADDR_CTRL, 8'h02);
      wait_ev(t0, r0);
      wait_ev(t1, r0);
      chk_n("period", 2 * WCLK_CYC, t1 - t0);
      rd("flag set", `PWT_ADDR_CTRL, 8'h82, 8'hFF);
      repeat (3000) @(posedge core_clk);
      wr(`PWT_ADDR_CTRL, 8'h02);
      rd("flag zero write", `PWT_ADDR_CTRL, 8'h82, 8'hFF);
      wait_ev(t2, r0);
      chk_n("same value", 2 * WCLK_CYC, t2 - t1);
      repeat (3000) @(posedge core_clk);
      wr(`PWT_ADDR_CTRL, 8'h43);
      rd("flag ack", `PWT_ADDR_CTRL, 8'h03, 8'hFF);
      wait_ev(t3, r0);
      chk_n("restart", 4 * WCLK_CYC, t3 - t2);
   endtask

   // Flag may set at any moment, so it is masked here
   task test_interlock;
      wr(`PWT_ADDR_RST, 8'h00);
      rd("reset clear", `PWT_ADDR_RST, 8'h00, 8'hFF);
      wr(`PWT_ADDR_CTRL, 8'h00);
      rd("zero refused", `PWT_ADDR_CTRL, 8'h03, 8'h7F);
      wr(`PWT_ADDR_RST, 8'h02);
      wr(`PWT_ADDR_CTRL, 8'h00);
      rd("zero taken", `PWT_ADDR_CTRL, 8'h00, 8'h7F);
      rd("forced divider", `PWT_ADDR_DIV, 8'h3F, 8'hFF);
      wr(`PWT_ADDR_RST, 8'h00);
      rd("clear refused", `PWT_ADDR_RST, 8'h02, 8'hFF);
   endtask

   task test_reset_priority;
      int t2;
      wr(`PWT_ADDR_DIV, 8'h00);
      wr(`PWT_ADDR_CTRL, 8'h41);
      wait_ev(t0, r0);
      chk("first event", 8'h00, {7'h00, r0});
      wr(`PWT_ADDR_CTRL, 8'h41);
      wait_ev(t1, r0);
      chk("second event", 8'h01, {7'h00, r0});
      chk("irq suppressed", 8'h00, {7'h00, wakeupIrq});
      chk_n("reset clock", WCLK_CYC, t1 - t0);
      rd("flag not set", `PWT_ADDR_CTRL, 8'h01, 8'hFF);
      wait_ev(t2, r0);
      chk("third event", 8'h00, {7'h00, r0});
      chk_n("after wrap", WCLK_CYC, t2 - t1);
   endtask

   // One divider step adds sixteen oscillator ticks per wakeup clock
   task test_divider_step;
      int t2;
      wr(`PWT_ADDR_DIV, 8'h01);
      wait_ev(t0, r0);
      wait_ev(t1, r0);
      wait_ev(t2, r0);
      chk_n("divider step", (504 + 16) * 4, t2 - t1);
   endtask

   initial
   begin
      reset = 1'b1;
      powerOnReset = 1'b1;
      lfoClk = 1'b0;
      lfoDiv = 2'h0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      cyc = 0;
      n_errors = 0;
      n_compared = 0;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      powerOnReset <= 1'b0;
      test_reset_values();
      test_interval_timing();
      test_interlock();
      test_reset_priority();
      test_divider_step();
      final_report();
   end
endmodule // test_pwt_timer
`default_nettype wire
